// *** design/excl_monitor.sv ***
// local exclusive monitor: one reservation of address and size
// assumes snoop pulses come from other masters writing the shared memory
`default_nettype none

module excl_monitor (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic arm_in,
    input wire logic [31:0] arm_addr_in,
    input wire lsu_pkg::size_t arm_size_in,
    input wire logic disarm_in,
    input wire logic snoop_in,
    input wire logic [31:0] snoop_addr_in,
    input wire logic [31:0] probe_addr_in,
    input wire lsu_pkg::size_t probe_size_in,
    output logic armed_out,
    output logic pass_out
);
    logic armed_reg;
    logic armed_next;
    logic [31:0] addr_reg;
    logic [31:0] addr_next;
    lsu_pkg::size_t size_reg;
    lsu_pkg::size_t size_next;

    // ========================================================
    // reservation: arming beats a clear in the same cycle
    always_comb begin
        armed_next = armed_reg;
        addr_next = addr_reg;
        size_next = size_reg;
        if (disarm_in) begin
            armed_next = 1'b0;
        end
        if (snoop_in && snoop_addr_in == addr_reg) begin
            armed_next = 1'b0;
        end
        if (arm_in) begin
            armed_next = 1'b1;
            addr_next = arm_addr_in;
            size_next = arm_size_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            armed_reg <= 1'b0;
            addr_reg <= 32'h0000_0000;
            size_reg <= lsu_pkg::SIZE_WORD;
        end else begin
            armed_reg <= armed_next;
            addr_reg <= addr_next;
            size_reg <= size_next;
        end
    end

    // mismatched address or size also fails, rather than guessing
    assign pass_out = armed_reg && addr_reg == probe_addr_in && size_reg == probe_size_in;
    assign armed_out = armed_reg;

    // ========================================================
    // checks
    snoop_clears_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        armed_reg && snoop_in && snoop_addr_in == addr_reg && !arm_in |=> !armed_reg)
        else $error("snoop hit did not clear reservation");
    arm_disarm_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (arm_in |=> armed_reg && addr_reg == $past(arm_addr_in)) and (disarm_in && !arm_in |=> !armed_reg))
        else $error("reservation did not follow arm or clear");
endmodule : excl_monitor

`default_nettype wire

// *** design/lsu_pkg.sv ***
// shared constants and types for the multiple and exclusive load/store unit
// assumes a 16-entry register file and a word-wide memory port on the core
// Operation
// - stack save stores highest register first, highest register at highest address
// - stack restore loads lowest register first, lowest register from lowest address
// - save is decrement-after store, restore increment-after load, stack pointer gets final address
// - a loaded program counter needs bit 0 set; branch goes to halfword address; the code does not check bit 0 and branches either way
// - exclusive loads read a word, a byte or a halfword
// - exclusive store status is 0 when performed, 1 when not performed
// - exclusive store succeeds only if nobody touched the location meanwhile
// - after clear-exclusive the next exclusive store fails, writes nothing, status 1
// - none of these operations alter the condition flags
// - increment-after walks word addresses upward, writeback is base plus 4 times count less one
`default_nettype none

package lsu_pkg;
    // ========================================================
    // register numbers and data layout
    localparam logic [3:0] REG_SP = 4'hD;
    localparam logic [3:0] REG_LR = 4'hE;
    localparam logic [3:0] REG_PC = 4'hF;
    localparam logic [31:0] WORD_STEP = 32'h0000_0004;
    localparam logic [31:0] STATUS_DONE = 32'h0000_0000;
    localparam logic [31:0] STATUS_FAILED = 32'h0000_0001;

    // ========================================================
    // operations, sizes, kinds and states
    typedef enum logic [3:0] {
        OP_MULTI_LOAD_IA = 4'h0,
        OP_MULTI_STORE_IA = 4'h1,
        OP_MULTI_LOAD_DB = 4'h2,
        OP_MULTI_STORE_DB = 4'h3,
        OP_EXCL_LOAD = 4'h4,
        OP_EXCL_STORE = 4'h5,
        OP_CLEAR_EXCL = 4'h6,
        OP_STACK_SAVE = 4'h7,
        OP_STACK_RESTORE = 4'h8
    } op_t;

    typedef enum logic [1:0] {
        SIZE_BYTE = 2'h0,
        SIZE_HALF = 2'h1,
        SIZE_WORD = 2'h2
    } size_t;

    typedef enum logic [1:0] {
        KIND_MULTI = 2'h0,
        KIND_EXCL_LOAD = 2'h1,
        KIND_EXCL_STORE = 2'h2
    } kind_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_ACCESS = 2'h1,
        ST_WAIT = 2'h2,
        ST_FINISH = 2'h3
    } state_t;

    // one command as handed over by the decoder
    typedef struct packed {
        op_t op;
        size_t size;
        logic writeback;
        logic [3:0] base_idx;
        logic [31:0] base_val;
        logic [15:0] reg_list;
        logic [3:0] xfer_idx;
        logic [3:0] status_idx;
        logic [7:0] offset_words;
    } cmd_t;
endpackage : lsu_pkg

`default_nettype wire

// *** design/multi_excl_lsu.sv ***
// load/store sequencer for multiple, stack and exclusive transfers
// assumes register file reads asynchronously and memory answers with mem_ack_in
`default_nettype none

module multi_excl_lsu #(
    parameter int DATA_W = 32,
    parameter int LIST_W = 16
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic cmd_valid_in,
    input wire lsu_pkg::cmd_t cmd_in,
    output logic cmd_ready_out,
    output logic done_out,
    output logic [3:0] rf_rd_idx_out,
    input wire logic [31:0] rf_rd_data_in,
    output logic rf_wr_en_out,
    output logic [3:0] rf_wr_idx_out,
    output logic [31:0] rf_wr_data_out,
    output logic mem_req_out,
    output logic mem_write_out,
    output lsu_pkg::size_t mem_size_out,
    output logic [31:0] mem_addr_out,
    output logic [31:0] mem_wdata_out,
    input wire logic mem_ack_in,
    input wire logic [31:0] mem_rdata_in,
    input wire logic snoop_in,
    input wire logic [31:0] snoop_addr_in,
    output logic branch_out,
    output logic [31:0] branch_addr_out,
    output logic reserved_out
);
    // ========================================================
    // elaboration checks
    if (DATA_W != 32 || LIST_W != 16) begin : g_bad_param
        $error("only a 32-bit word and a 16-register list are supported");
    end

    // ========================================================
    // list helpers
    function automatic logic [3:0] lowest_set(input logic [15:0] list);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = 15; i >= 0; i--) begin
            if (list[i]) idx = 4'(i);
        end
        return idx;
    endfunction : lowest_set

    function automatic logic [3:0] highest_set(input logic [15:0] list);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = 0; i < 16; i++) begin
            if (list[i]) idx = 4'(i);
        end
        return idx;
    endfunction : highest_set

    lsu_pkg::state_t state_reg, state_next;
    lsu_pkg::kind_t kind_reg, kind_next;
    lsu_pkg::size_t size_reg, size_next;
    logic load_reg, load_next;
    logic decr_reg, decr_next;
    logic wb_reg, wb_next;
    logic [3:0] base_idx_reg, base_idx_next;
    logic [3:0] status_idx_reg, status_idx_next;
    logic [31:0] status_val_reg, status_val_next;
    logic [15:0] remaining_reg, remaining_next;
    logic [31:0] addr_reg, addr_next;
    logic ready_reg, ready_next;
    logic done_reg, done_next;
    logic [3:0] rd_idx_reg, rd_idx_next;
    logic wr_en_reg, wr_en_next;
    logic [3:0] wr_idx_reg, wr_idx_next;
    logic [31:0] wr_data_reg, wr_data_next;
    logic req_reg, req_next;
    logic write_reg, write_next;
    lsu_pkg::size_t msize_reg, msize_next;
    logic [31:0] maddr_reg, maddr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic branch_reg, branch_next;
    logic [31:0] baddr_reg, baddr_next;
    logic mon_arm, mon_disarm, mon_pass, mon_armed;
    logic [31:0] excl_addr;
    logic [31:0] load_val;
    logic [15:0] left_after;
    logic accept;

    assign accept = cmd_valid_in && ready_reg;
    // offset counts words, so 0 to 255 words covers byte offsets 0 to 1020
    assign excl_addr = cmd_in.base_val + {22'h0, cmd_in.offset_words, 2'b00};
    assign left_after = remaining_reg & ~(16'h0001 << rd_idx_reg);

    excl_monitor u_monitor (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .arm_in(mon_arm),
        .arm_addr_in(addr_reg),
        .arm_size_in(size_reg),
        .disarm_in(mon_disarm),
        .snoop_in(snoop_in),
        .snoop_addr_in(snoop_addr_in),
        .probe_addr_in(excl_addr),
        .probe_size_in(cmd_in.size),
        .armed_out(mon_armed),
        .pass_out(mon_pass)
    );

    // ========================================================
    // loaded data, zero extended from the low lanes
    always_comb begin
        case (size_reg)
            lsu_pkg::SIZE_BYTE: load_val = {24'h0, mem_rdata_in[7:0]};
            lsu_pkg::SIZE_HALF: load_val = {16'h0, mem_rdata_in[15:0]};
            default: load_val = mem_rdata_in;
        endcase
    end

    // ========================================================
    // sequencer next state; no path here touches condition flags
    always_comb begin
        state_next = state_reg;
        kind_next = kind_reg;
        size_next = size_reg;
        load_next = load_reg;
        decr_next = decr_reg;
        wb_next = wb_reg;
        base_idx_next = base_idx_reg;
        status_idx_next = status_idx_reg;
        status_val_next = status_val_reg;
        remaining_next = remaining_reg;
        addr_next = addr_reg;
        ready_next = ready_reg;
        done_next = 1'b0;
        rd_idx_next = rd_idx_reg;
        wr_en_next = 1'b0;
        wr_idx_next = wr_idx_reg;
        wr_data_next = wr_data_reg;
        req_next = req_reg;
        write_next = write_reg;
        msize_next = msize_reg;
        maddr_next = maddr_reg;
        wdata_next = wdata_reg;
        branch_next = 1'b0;
        baddr_next = baddr_reg;
        mon_arm = 1'b0;
        mon_disarm = 1'b0;
        case (state_reg)
            lsu_pkg::ST_IDLE: begin
                if (accept) begin
                    ready_next = 1'b0;
                    state_next = lsu_pkg::ST_ACCESS;
                    kind_next = lsu_pkg::KIND_MULTI;
                    size_next = lsu_pkg::SIZE_WORD;
                    load_next = cmd_in.op == lsu_pkg::OP_MULTI_LOAD_IA || cmd_in.op == lsu_pkg::OP_MULTI_LOAD_DB
                        || cmd_in.op == lsu_pkg::OP_STACK_RESTORE || cmd_in.op == lsu_pkg::OP_EXCL_LOAD;
                    decr_next = cmd_in.op == lsu_pkg::OP_MULTI_STORE_DB || cmd_in.op == lsu_pkg::OP_MULTI_LOAD_DB
                        || cmd_in.op == lsu_pkg::OP_STACK_SAVE;
                    wb_next = cmd_in.writeback;
                    base_idx_next = cmd_in.base_idx;
                    status_idx_next = cmd_in.status_idx;
                    remaining_next = cmd_in.reg_list;
                    addr_next = cmd_in.base_val;
                    case (cmd_in.op)
                        lsu_pkg::OP_STACK_SAVE, lsu_pkg::OP_STACK_RESTORE: begin
                            base_idx_next = lsu_pkg::REG_SP;
                            wb_next = 1'b1;
                        end
                        lsu_pkg::OP_EXCL_LOAD, lsu_pkg::OP_EXCL_STORE: begin
                            kind_next = cmd_in.op == lsu_pkg::OP_EXCL_LOAD ? lsu_pkg::KIND_EXCL_LOAD
                                : lsu_pkg::KIND_EXCL_STORE;
                            size_next = cmd_in.size;
                            wb_next = 1'b0;
                            remaining_next = 16'h0001 << cmd_in.xfer_idx;
                            addr_next = excl_addr;
                            status_val_next = lsu_pkg::STATUS_DONE;
                            if (cmd_in.op == lsu_pkg::OP_EXCL_STORE) begin
                                mon_disarm = 1'b1;
                                if (!mon_pass) begin
                                    status_val_next = lsu_pkg::STATUS_FAILED;
                                    state_next = lsu_pkg::ST_FINISH;
                                end
                            end
                        end
                        lsu_pkg::OP_CLEAR_EXCL: begin
                            mon_disarm = 1'b1;
                            done_next = 1'b1;
                            ready_next = 1'b1;
                            state_next = lsu_pkg::ST_IDLE;
                        end
                        default: begin
                        end
                    endcase
                    // an empty list has nothing to move; finish without writeback
                    if (cmd_in.op != lsu_pkg::OP_CLEAR_EXCL && remaining_next == 16'h0000) begin
                        wb_next = 1'b0;
                        state_next = lsu_pkg::ST_FINISH;
                    end
                    rd_idx_next = decr_next ? highest_set(remaining_next) : lowest_set(remaining_next);
                end
            end
            lsu_pkg::ST_ACCESS: begin
                req_next = 1'b1;
                write_next = !load_reg;
                msize_next = size_reg;
                maddr_next = addr_reg;
                wdata_next = rf_rd_data_in;
                state_next = lsu_pkg::ST_WAIT;
            end
            lsu_pkg::ST_WAIT: begin
                if (mem_ack_in) begin
                    req_next = 1'b0;
                    remaining_next = left_after;
                    if (load_reg && rd_idx_reg == lsu_pkg::REG_PC) begin
                        branch_next = 1'b1;
                        baddr_next = {load_val[31:1], 1'b0};
                    end else if (load_reg) begin
                        wr_en_next = 1'b1;
                        wr_idx_next = rd_idx_reg;
                        wr_data_next = load_val;
                    end
                    if (kind_reg == lsu_pkg::KIND_EXCL_LOAD) begin
                        mon_arm = 1'b1;
                    end
                    if (left_after == 16'h0000) begin
                        state_next = lsu_pkg::ST_FINISH;
                    end else begin
                        state_next = lsu_pkg::ST_ACCESS;
                        rd_idx_next = decr_reg ? highest_set(left_after) : lowest_set(left_after);
                        addr_next = decr_reg ? addr_reg - lsu_pkg::WORD_STEP : addr_reg + lsu_pkg::WORD_STEP;
                    end
                end
            end
            lsu_pkg::ST_FINISH: begin
                if (kind_reg == lsu_pkg::KIND_EXCL_STORE) begin
                    wr_en_next = 1'b1;
                    wr_idx_next = status_idx_reg;
                    wr_data_next = status_val_reg;
                end else if (wb_reg) begin
                    // addr_reg still holds the final access address
                    wr_en_next = 1'b1;
                    wr_idx_next = base_idx_reg;
                    wr_data_next = addr_reg;
                end
                done_next = 1'b1;
                ready_next = 1'b1;
                state_next = lsu_pkg::ST_IDLE;
            end
            default: begin
                state_next = lsu_pkg::ST_IDLE;
                ready_next = 1'b1;
            end
        endcase
    end

    // ========================================================
    // state registers
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            state_reg <= lsu_pkg::ST_IDLE;
            kind_reg <= lsu_pkg::KIND_MULTI;
            size_reg <= lsu_pkg::SIZE_WORD;
            load_reg <= 1'b0;
            decr_reg <= 1'b0;
            wb_reg <= 1'b0;
            base_idx_reg <= 4'h0;
            status_idx_reg <= 4'h0;
            status_val_reg <= 32'h0000_0000;
            remaining_reg <= 16'h0000;
            addr_reg <= 32'h0000_0000;
            ready_reg <= 1'b0;
            done_reg <= 1'b0;
            rd_idx_reg <= 4'h0;
            wr_en_reg <= 1'b0;
            wr_idx_reg <= 4'h0;
            wr_data_reg <= 32'h0000_0000;
            req_reg <= 1'b0;
            write_reg <= 1'b0;
            msize_reg <= lsu_pkg::SIZE_WORD;
            maddr_reg <= 32'h0000_0000;
            wdata_reg <= 32'h0000_0000;
            branch_reg <= 1'b0;
            baddr_reg <= 32'h0000_0000;
        end else begin
            state_reg <= state_next;
            kind_reg <= kind_next;
            size_reg <= size_next;
            load_reg <= load_next;
            decr_reg <= decr_next;
            wb_reg <= wb_next;
            base_idx_reg <= base_idx_next;
            status_idx_reg <= status_idx_next;
            status_val_reg <= status_val_next;
            remaining_reg <= remaining_next;
            addr_reg <= addr_next;
            ready_reg <= state_next == lsu_pkg::ST_IDLE ? 1'b1 : ready_next;
            done_reg <= done_next;
            rd_idx_reg <= rd_idx_next;
            wr_en_reg <= wr_en_next;
            wr_idx_reg <= wr_idx_next;
            wr_data_reg <= wr_data_next;
            req_reg <= req_next;
            write_reg <= write_next;
            msize_reg <= msize_next;
            maddr_reg <= maddr_next;
            wdata_reg <= wdata_next;
            branch_reg <= branch_next;
            baddr_reg <= baddr_next;
        end
    end

    assign cmd_ready_out = ready_reg;
    assign done_out = done_reg;
    assign rf_rd_idx_out = rd_idx_reg;
    assign rf_wr_en_out = wr_en_reg;
    assign rf_wr_idx_out = wr_idx_reg;
    assign rf_wr_data_out = wr_data_reg;
    assign mem_req_out = req_reg;
    assign mem_write_out = write_reg;
    assign mem_size_out = msize_reg;
    assign mem_addr_out = maddr_reg;
    assign mem_wdata_out = wdata_reg;
    assign branch_out = branch_reg;
    assign branch_addr_out = baddr_reg;
    assign reserved_out = mon_armed;

    // ========================================================
    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    sequence step_done_s;
        state_reg == lsu_pkg::ST_WAIT && mem_ack_in && left_after != 16'h0000;
    endsequence
    sequence excl_fail_s;
        accept && cmd_in.op == lsu_pkg::OP_EXCL_STORE && !mon_pass;
    endsequence
    sequence clear_then_store_s;
        accept && cmd_in.op == lsu_pkg::OP_CLEAR_EXCL ##1 accept && cmd_in.op == lsu_pkg::OP_EXCL_STORE;
    endsequence

    save_order_a: assert property (step_done_s and (decr_reg && !load_reg) |->
        ##2 mem_addr_out == $past(mem_addr_out, 2) - 32'h4 && rf_rd_idx_out < $past(rf_rd_idx_out, 2))
        else $error("descending store order broken");
    restore_order_a: assert property (step_done_s and (!decr_reg && load_reg) |->
        ##2 mem_addr_out == $past(mem_addr_out, 2) + 32'h4 && rf_rd_idx_out > $past(rf_rd_idx_out, 2))
        else $error("ascending load order broken");
    base_writeback_a: assert property (state_reg == lsu_pkg::ST_FINISH && wb_reg
        && kind_reg == lsu_pkg::KIND_MULTI |=> rf_wr_en_out && rf_wr_idx_out == $past(base_idx_reg)
        && rf_wr_data_out == mem_addr_out && done_out)
        else $error("base writeback wrong");
    pc_branch_a: assert property (state_reg == lsu_pkg::ST_WAIT && mem_ack_in && load_reg
        && rd_idx_reg == lsu_pkg::REG_PC |=> branch_out && !rf_wr_en_out && branch_addr_out[0] == 1'b0)
        else $error("program counter load did not branch");
    excl_status_a: assert property (excl_fail_s |-> ##2 rf_wr_en_out && rf_wr_data_out == 32'h1
        && !mem_req_out && done_out)
        else $error("failed exclusive store status wrong");
    clear_fails_a: assert property (clear_then_store_s |-> !req_reg [*3] ##0
        (rf_wr_en_out && rf_wr_data_out == 32'h1))
        else $error("store after clear did not fail");
    excl_size_a: assert property (accept && cmd_in.op == lsu_pkg::OP_EXCL_LOAD |->
        ##2 mem_req_out && !mem_write_out && mem_size_out == $past(cmd_in.size, 2))
        else $error("exclusive load size wrong");
endmodule : multi_excl_lsu

`default_nettype wire

// *** test/mem_partner.sv ***
// system memory model on the far side of the lsu memory port
// assumes aligned accesses below byte address 0x100
`default_nettype none

module mem_partner (
    input wire logic clk_in,
    input wire logic req_in,
    input wire logic write_in,
    input wire lsu_pkg::size_t size_in,
    input wire logic [31:0] addr_in,
    input wire logic [31:0] wdata_in,
    output logic ack_out,
    output logic [31:0] rdata_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] mem [64];
    logic [31:0] m;
    int wait_cnt = 0;
    // ==========================================
    // answer after 0..2 cycles; read data is garbage outside the ack cycle
    initial begin
        ack_out = 1'b0;
        rdata_out = 32'h0;
    end
    always @(negedge clk_in) begin
        m = (size_in == lsu_pkg::SIZE_BYTE) ? 32'hFF : (size_in == lsu_pkg::SIZE_HALF) ? 32'hFFFF : 32'hFFFFFFFF;
        ack_out <= 1'b0;
        rdata_out <= ~rdata_out;
        if (req_in && wait_cnt == 0) begin
            ack_out <= 1'b1;
            wait_cnt = $urandom % 3;
            rdata_out <= mem[addr_in[7:2]];
            if (write_in) mem[addr_in[7:2]] <= (mem[addr_in[7:2]] & ~m) | (wdata_in & m);
        end else if (req_in) begin
            wait_cnt--;
        end
    end
endmodule : mem_partner

`default_nettype wire

// *** test/stack_multiple_and_exclusive_access_test.sv ***
// bench for the multiple, stack and exclusive sequencer
// assumes mem_partner for memory; register file lives here
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_total++; $display("[ERR] %0t got %h want %h", $time, a, b); end end

module stack_multiple_and_exclusive_access_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 0, rstn_in = 0, cmd_valid_in = 0, snoop_in = 0;
    lsu_pkg::cmd_t cmd_in = '0;
    logic [31:0] snoop_addr_in = 0, br = 0, sp, a, m, v;
    logic [31:0] rf [16], keep [16];
    logic [15:0] lst;
    logic cmd_ready_out, done_out, rf_wr_en_out, mem_req_out, mem_write_out, mem_ack_in, branch_out, reserved_out;
    logic [3:0] rf_rd_idx_out, rf_wr_idx_out;
    logic [31:0] rf_wr_data_out, mem_addr_out, mem_wdata_out, mem_rdata_in, branch_addr_out;
    lsu_pkg::size_t mem_size_out;
    int err_total = 0, num_checks = 0, cyc = 0, s, r;
    wire logic [31:0] rf_rd_data_in = rf[rf_rd_idx_out];

    multi_excl_lsu uut (.clk_in(clk_in), .rstn_in(rstn_in), .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in),
        .cmd_ready_out(cmd_ready_out), .done_out(done_out), .rf_rd_idx_out(rf_rd_idx_out), .rf_rd_data_in(rf_rd_data_in),
        .rf_wr_en_out(rf_wr_en_out), .rf_wr_idx_out(rf_wr_idx_out), .rf_wr_data_out(rf_wr_data_out),
        .mem_req_out(mem_req_out), .mem_write_out(mem_write_out), .mem_size_out(mem_size_out),
        .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out), .mem_ack_in(mem_ack_in),
        .mem_rdata_in(mem_rdata_in), .snoop_in(snoop_in), .snoop_addr_in(snoop_addr_in), .branch_out(branch_out),
        .branch_addr_out(branch_addr_out), .reserved_out(reserved_out));
    mem_partner mem (.clk_in(clk_in), .req_in(mem_req_out), .write_in(mem_write_out), .size_in(mem_size_out),
        .addr_in(mem_addr_out), .wdata_in(mem_wdata_out), .ack_out(mem_ack_in), .rdata_out(mem_rdata_in));

    // ==========================================
    // clock, register file writes and hang guard
    initial begin
        forever #25 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cyc++;
        if (rf_wr_en_out) rf[rf_wr_idx_out] <= rf_wr_data_out;
        if (branch_out) br <= branch_addr_out;
        if (cyc == 20000) begin
            err_total++;
            $display("[ERR] %0t cycle limit reached", $time);
            finish_test();
        end
    end

    function automatic lsu_pkg::cmd_t mk(lsu_pkg::op_t op, int sz, logic [31:0] base, logic [15:0] l, int st);
        lsu_pkg::cmd_t c;
        c = '0;
        c.op = op;
        c.size = lsu_pkg::size_t'(sz);
        c.writeback = 1'b1;
        c.base_idx = 4'hD;
        c.base_val = base;
        c.reg_list = l;
        c.xfer_idx = 4'(st);
        c.status_idx = 4'h3;
        return c;
    endfunction : mk

    // offer one command once ready, then wait a bounded time for done
    task automatic run(input lsu_pkg::cmd_t c);
        int n;
        n = 0;
        while (cmd_ready_out !== 1'b1 && n < 100) begin @(negedge clk_in); n++; end
        cmd_in = c;
        cmd_valid_in = 1'b1;
        @(negedge clk_in);
        // clear answers at once; valid stays up so the next command is taken back to back
        if (c.op == lsu_pkg::OP_CLEAR_EXCL) begin
            `CHK(done_out, 1'b1)
            return;
        end
        cmd_valid_in = 1'b0;
        while (done_out !== 1'b1 && n < 300) begin @(negedge clk_in); n++; end
        if (n >= 300) begin
            err_total++;
            $display("[ERR] %0t command never finished", $time);
        end
        // the closing register write lands one edge after done
        @(negedge clk_in);
    endtask : run

    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test

    // ==========================================
    // stack save/restore, program counter pop, then every exclusive size
    initial begin
        void'($urandom(24896));
        for (r = 0; r < 16; r++) rf[r] = $urandom;
        repeat (2) @(negedge clk_in);
        rstn_in = 1'b1;
        for (s = 0; s < 5; s++) begin
            lst = (s == 0) ? 16'h0001 : (s == 1) ? 16'h5FFF : (16'($urandom) & 16'h5FFF) | 16'h0002;
            sp = 32'hC0 + 4 * ($urandom % 16);
            run(mk(lsu_pkg::OP_STACK_SAVE, 2, sp, lst, 0));
            a = sp;
            for (r = 15; r >= 0; r--) if (lst[r]) begin `CHK(mem.mem[a[7:2]], rf[r]) a -= 4; end
            `CHK(rf[13], a + 4)
            for (r = 0; r < 16; r++) begin keep[r] = rf[r]; if (lst[r]) rf[r] = ~rf[r]; end
            run(mk(lsu_pkg::OP_STACK_RESTORE, 2, rf[13], lst, 0));
            for (r = 0; r < 13; r++) `CHK(rf[r], keep[r])
            `CHK(rf[13], sp)
        end
        mem.mem[16] = 32'h1234; v = 32'($urandom) | 32'h1; mem.mem[17] = v;
        run(mk(lsu_pkg::OP_STACK_RESTORE, 2, 32'h40, 16'h8001, 0));
        `CHK(br, v & 32'hFFFFFFFE)
        `CHK(rf[0], 32'h1234)
        for (s = 0; s < 3; s++) begin
            a = 32'h10 + 8 * s;
            m = (s == 0) ? 32'hFF : (s == 1) ? 32'hFFFF : 32'hFFFFFFFF;
            mem.mem[a[7:2]] = $urandom;
            run(mk(lsu_pkg::OP_EXCL_LOAD, s, a, 0, 1));
            `CHK(rf[1], mem.mem[a[7:2]] & m)
            `CHK(reserved_out, 1'b1)
            rf[3] = 32'h5;
            run(mk(lsu_pkg::OP_EXCL_STORE, s, a, 0, 2));
            `CHK(rf[3], 32'h0)
            `CHK(mem.mem[a[7:2]] & m, rf[2] & m)
            rf[2] = ~rf[2];
            run(mk(lsu_pkg::OP_EXCL_STORE, s, a, 0, 2));
            `CHK(rf[3], 32'h1)
            run(mk(lsu_pkg::OP_EXCL_LOAD, s, a, 0, 1));
            run(mk(lsu_pkg::OP_CLEAR_EXCL, s, a, 0, 1));
            rf[3] = 32'h5;
            run(mk(lsu_pkg::OP_EXCL_STORE, s, a, 0, 2));
            `CHK(rf[3], 32'h1)
            `CHK(mem.mem[a[7:2]] & m, rf[1] & m)
            run(mk(lsu_pkg::OP_EXCL_LOAD, s, a, 0, 1));
            snoop_addr_in = a;
            snoop_in = 1'b1;
            @(negedge clk_in);
            snoop_in = 1'b0;
            run(mk(lsu_pkg::OP_EXCL_STORE, s, a, 0, 2));
            `CHK(rf[3], 32'h1)
        end
        finish_test();
    end
endmodule : stack_multiple_and_exclusive_access_test

`default_nettype wire
